// ===== iackc_pkg.sv
// Shared constants, register map and carrier types of the acknowledge control block
package iackc_pkg;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int SCL_HALF_NS = 5000;
    // Least time, rounded up to whole cycles
    localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BITS_PER_BYTE = 8;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_RXDATA = 4'h8;
    localparam int CTRL_ACK_VALUE = 0;
    localparam int CTRL_ACK_TRIG = 1;
    localparam int CTRL_RX_TRIG = 2;
    localparam int CTRL_ADDR_HOLD = 3;
    localparam int CTRL_DATA_HOLD = 4;
    localparam int CTRL_MASTER = 5;
    localparam int STAT_BUSY = 0;
    localparam int STAT_AWAIT_ACK = 1;
    localparam int STAT_SLAVE_ACK = 2;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    // Control register fields, bit 5 first
    typedef struct packed {
        logic master_mode;
        logic data_hold_enable;
        logic address_hold_enable;
        logic master_receive_trigger;
        logic ack_sequence_trigger;
        logic ack_value_select;
    } iackc_ctrl_s;
    localparam iackc_ctrl_s CTRL_RESET = '0;

    // Open-drain pin drive
    typedef struct packed {
        logic scl_oe;
        logic sda_oe;
    } iackc_pins_s;

    // Master engine states
    typedef enum logic [2:0] {
        M_IDLE = 3'b000,
        M_RX_LOW = 3'b001,
        M_RX_HIGH = 3'b010,
        M_ACK_LOW = 3'b011,
        M_ACK_HIGH = 3'b100,
        M_ACK_END = 3'b101
    } iackc_mst_e;

    // Slave acknowledge states
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_WAIT_RISE = 2'b01,
        S_WAIT_FALL = 2'b10
    } iackc_slv_e;
endpackage

// ===== iackc_half_timer.sv
// Half-bit timer of the serial clock, one-cycle tick at the end of each half period
`timescale 1ns/1ps
module iackc_half_timer #(
    parameter int HALF_CYC = iackc_pkg::SCL_HALF_CYC
) (
    input wire logic clk,     // System clock
    input wire logic sys_rst, // Async reset, active high
    input wire logic restart, // Start a new half period
    output logic tick         // End of half period
);
    import iackc_pkg::*;

    localparam int CW = $clog2(HALF_CYC + 1);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic tick_d;

    // Elaboration check
    if (HALF_CYC < 2) begin : g_bad
        $error("HALF_CYC must be at least 2");
    end

    // Count down to the tick
    always_comb begin
        tick_d = 1'b0;
        cnt_d = cnt_q;
        if (restart) begin
            cnt_d = CW'(HALF_CYC - 1);
        end else if (cnt_q == '0) begin
            cnt_d = CW'(HALF_CYC - 1);
        end else begin
            cnt_d = cnt_q - 1'b1;
            tick_d = (cnt_q == CW'(1));
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick <= tick_d;
        end
    end
endmodule

// ===== iackc_core.sv
// Acknowledge control: master receive byte, acknowledge sequence, slave held acknowledge
`timescale 1ns/1ps
// Contract
// - Master receive acknowledge drives value setting: 1 gives NACK, 0 gives ACK.
// - Slave with address or data hold sends value setting as acknowledge bit.
// - Acknowledge trigger works only as master during master receive.
// - Writing 1 to trigger runs acknowledge sequence carrying current value setting.
// - Acknowledge trigger reads 0 while no acknowledge sequence runs.
// - Receive trigger clears by hardware at end of the 8-bit byte.
module iackc_core #(
    parameter int HALF_CYC = iackc_pkg::SCL_HALF_CYC
) (
    input wire logic clk,                           // System clock, 40 MHz
    input wire logic sys_rst,                       // Async reset, active high
    input wire logic [iackc_pkg::ADDR_W-1:0] addr,  // Register byte address
    input wire logic [31:0] wdata,                  // Write data
    input wire logic wr,                            // Write strobe
    input wire logic rd,                            // Read strobe
    output logic [31:0] rdata,                      // Read data, cycle after rd
    input wire logic serial_clock_pin_in,           // Clock line level
    output logic serial_clock_pin_out,              // Clock line drive value
    output logic serial_clock_pin_oe,               // Clock line pulled low
    input wire logic serial_data_pin_in,            // Data line level
    output logic serial_data_pin_out,               // Data line drive value
    output logic serial_data_pin_oe,                // Data line pulled low
    input wire logic slave_ack_slot                 // Slave byte done, ack slot begins
);
    import iackc_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    iackc_ctrl_s ctrl_q, ctrl_d;
    iackc_mst_e mst_q, mst_d;
    iackc_slv_e slv_q, slv_d;
    iackc_pins_s pins_q, pins_d;
    logic [3:0] bit_cnt_q, bit_cnt_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] rx_data_q, rx_data_d;
    logic await_ack_q, await_ack_d;
    logic ack_bit_q, ack_bit_d;
    logic slv_bit_q, slv_bit_d;
    logic scl_prev_q;
    logic [31:0] rdata_d;
    logic tick;
    logic restart;
    logic ctrl_wr;
    logic ack_go;
    logic rx_go;

    if (HALF_CYC < 2) begin : g_bad
        $error("HALF_CYC must be at least 2");
    end

    iackc_half_timer #(.HALF_CYC(HALF_CYC)) u_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .restart(restart),
        .tick(tick)
    );

    // ************************************************************
    // Master engine and control register
    // ************************************************************
    assign ctrl_wr = wr && (addr == OFS_CTRL);
    assign ack_go = ctrl_wr && wdata[CTRL_ACK_TRIG] && ctrl_q.master_mode
                    && (mst_q == M_IDLE) && await_ack_q;
    assign rx_go = ctrl_wr && wdata[CTRL_RX_TRIG] && ctrl_q.master_mode
                   && (mst_q == M_IDLE) && !await_ack_q;
    assign restart = ack_go || rx_go;

    // Next state of master, control and capture
    always_comb begin
        ctrl_d = ctrl_q;
        mst_d = mst_q;
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        rx_data_d = rx_data_q;
        await_ack_d = await_ack_q;
        ack_bit_d = ack_bit_q;
        if (ctrl_wr) begin
            ctrl_d.ack_value_select = wdata[CTRL_ACK_VALUE];
            ctrl_d.address_hold_enable = wdata[CTRL_ADDR_HOLD];
            ctrl_d.data_hold_enable = wdata[CTRL_DATA_HOLD];
            ctrl_d.master_mode = wdata[CTRL_MASTER];
        end
        unique case (mst_q)
            M_IDLE: begin
                if (ack_go) begin
                    ctrl_d.ack_sequence_trigger = 1'b1;
                    ack_bit_d = wdata[CTRL_ACK_VALUE];
                    mst_d = M_ACK_LOW;
                end else if (rx_go) begin
                    ctrl_d.master_receive_trigger = 1'b1;
                    bit_cnt_d = '0;
                    mst_d = M_RX_LOW;
                end
            end
            M_RX_LOW: begin
                if (tick) begin
                    mst_d = M_RX_HIGH;
                end
            end
            M_RX_HIGH: begin
                if (tick) begin
                    shift_d = {shift_q[6:0], serial_data_pin_in};
                    bit_cnt_d = bit_cnt_q + 1'b1;
                    mst_d = M_RX_LOW;
                    if (bit_cnt_q == 4'(BITS_PER_BYTE - 1)) begin
                        ctrl_d.master_receive_trigger = 1'b0;
                        rx_data_d = {shift_q[6:0], serial_data_pin_in};
                        await_ack_d = 1'b1;
                        mst_d = M_IDLE;
                    end
                end
            end
            M_ACK_LOW: begin
                if (tick) begin
                    mst_d = M_ACK_HIGH;
                end
            end
            M_ACK_HIGH: begin
                if (tick) begin
                    mst_d = M_ACK_END;
                end
            end
            M_ACK_END: begin
                if (tick) begin
                    ctrl_d.ack_sequence_trigger = 1'b0;
                    await_ack_d = 1'b0;
                    mst_d = M_IDLE;
                end
            end
            default: begin
                mst_d = M_IDLE;
            end
        endcase
    end

    // ************************************************************
    // Slave held acknowledge
    // ************************************************************
    always_comb begin
        slv_d = slv_q;
        slv_bit_d = slv_bit_q;
        unique case (slv_q)
            S_IDLE: begin
                if (slave_ack_slot && !ctrl_q.master_mode) begin
                    slv_bit_d = (ctrl_q.address_hold_enable || ctrl_q.data_hold_enable)
                                ? ctrl_q.ack_value_select : 1'b0;
                    slv_d = S_WAIT_RISE;
                end
            end
            S_WAIT_RISE: begin
                if (serial_clock_pin_in && !scl_prev_q) begin
                    slv_d = S_WAIT_FALL;
                end
            end
            S_WAIT_FALL: begin
                if (!serial_clock_pin_in && scl_prev_q) begin
                    slv_d = S_IDLE;
                end
            end
            default: begin
                slv_d = S_IDLE;
            end
        endcase
    end

    // ************************************************************
    // Pin drive, from next state so pins align with state
    // ************************************************************
    always_comb begin
        pins_d.scl_oe = (mst_d == M_RX_LOW) || (mst_d == M_ACK_LOW) || (mst_d == M_ACK_END)
                        || ((mst_d == M_IDLE) && await_ack_d);
        pins_d.sda_oe = ((mst_d == M_ACK_LOW) || (mst_d == M_ACK_HIGH) || (mst_d == M_ACK_END))
                        && !ack_bit_d;
        if ((slv_d != S_IDLE) && !slv_bit_d) begin
            pins_d.sda_oe = 1'b1;
        end
    end

    // Register read mux
    always_comb begin
        rdata_d = '0;
        if (rd) begin
            unique case (addr)
                OFS_CTRL: rdata_d = {26'h0, ctrl_q};
                OFS_STATUS: rdata_d = {29'h0, slv_q != S_IDLE, await_ack_q, mst_q != M_IDLE};
                OFS_RXDATA: rdata_d = {24'h0, rx_data_q};
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q <= CTRL_RESET;
            mst_q <= M_IDLE;
            slv_q <= S_IDLE;
            pins_q <= '0;
            bit_cnt_q <= '0;
            shift_q <= '0;
            rx_data_q <= '0;
            await_ack_q <= 1'b0;
            ack_bit_q <= 1'b0;
            slv_bit_q <= 1'b0;
            scl_prev_q <= 1'b1;
            rdata <= REG_RESET;
            serial_clock_pin_out <= 1'b0;
            serial_data_pin_out <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            mst_q <= mst_d;
            slv_q <= slv_d;
            pins_q <= pins_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
            rx_data_q <= rx_data_d;
            await_ack_q <= await_ack_d;
            ack_bit_q <= ack_bit_d;
            slv_bit_q <= slv_bit_d;
            scl_prev_q <= serial_clock_pin_in;
            rdata <= rdata_d;
            serial_clock_pin_out <= 1'b0;
            serial_data_pin_out <= 1'b0;
        end
    end
    assign serial_clock_pin_oe = pins_q.scl_oe;
    assign serial_data_pin_oe = pins_q.sda_oe;

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_ack_value_master;
        @(posedge clk) disable iff (sys_rst)
        (mst_q == M_ACK_HIGH) |-> (serial_data_pin_oe == !ack_bit_q) && !serial_clock_pin_oe;
    endproperty
    a_ack_value_master: assert property (p_ack_value_master)
        else $error("master ack bit wrong on data line");

    property p_slave_value;
        @(posedge clk) disable iff (sys_rst)
        (slave_ack_slot && slv_q == S_IDLE && !ctrl_q.master_mode
         && ctrl_q.address_hold_enable && ctrl_q.ack_value_select)
        |=> (slv_q == S_WAIT_RISE) && !serial_data_pin_oe;
    endproperty
    a_slave_value: assert property (p_slave_value)
        else $error("held slave did not send NACK");

    property p_mode_gate;
        @(posedge clk) disable iff (sys_rst)
        (ctrl_wr && wdata[CTRL_ACK_TRIG] && !ctrl_q.master_mode && mst_q == M_IDLE)
        |=> (mst_q == M_IDLE) && !ctrl_q.ack_sequence_trigger;
    endproperty
    a_mode_gate: assert property (p_mode_gate)
        else $error("ack trigger acted outside master receive");

    property p_ack_start;
        @(posedge clk) disable iff (sys_rst)
        ack_go |=> (mst_q == M_ACK_LOW) && ctrl_q.ack_sequence_trigger
                   && (ack_bit_q == $past(wdata[CTRL_ACK_VALUE])) && serial_clock_pin_oe;
    endproperty
    a_ack_start: assert property (p_ack_start)
        else $error("ack sequence did not start");

    property p_idle_reads_zero;
        @(posedge clk) disable iff (sys_rst)
        (mst_q == M_IDLE) |-> !ctrl_q.ack_sequence_trigger;
    endproperty
    a_idle_reads_zero: assert property (p_idle_reads_zero)
        else $error("ack trigger set while idle");

    property p_rx_clear;
        @(posedge clk) disable iff (sys_rst)
        (mst_q == M_RX_HIGH && tick && bit_cnt_q == 4'h7)
        |=> !ctrl_q.master_receive_trigger && await_ack_q ##1 (rx_data_q == $past(rx_data_q));
    endproperty
    a_rx_clear: assert property (p_rx_clear)
        else $error("receive trigger not cleared after byte");

    property p_ack_selfclear;
        @(posedge clk) disable iff (sys_rst)
        (mst_q == M_ACK_END && tick)
        |=> !ctrl_q.ack_sequence_trigger && !serial_clock_pin_oe && !serial_data_pin_oe;
    endproperty
    a_ack_selfclear: assert property (p_ack_selfclear)
        else $error("ack trigger did not clear with clock released");
endmodule

// ===== iackc_far_model.sv
// Far-side bus device: sends one byte to a receiving master, clocks a slave ack slot
`timescale 1ns/1ps
module iackc_far_model #(
    parameter int HALF = 4
) (
    input wire logic clk,           // System clock
    input wire logic sys_rst,       // Async reset, active high
    input wire logic scl,           // Resolved clock line
    input wire logic [7:0] tx_byte, // Byte to send, MSB first
    input wire logic arm,           // Pulse: prepare to send tx_byte
    input wire logic burst,         // Pulse: make one clock pulse on the line
    output logic scl_oe,            // High pulls clock line low
    output logic sda_oe             // High pulls data line low
);
    logic scl_q;
    logic [3:0] bit_cnt;
    int burst_cnt;
    // ************************************************************
    // Byte transmitter and clock burst
    // ************************************************************
    // New bit after each falling clock edge, line released after the byte
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_q <= 1'b1;
            bit_cnt <= 4'h8;
            sda_oe <= 1'b0;
            burst_cnt <= 0;
        end else begin
            scl_q <= scl;
            if (arm) begin
                bit_cnt <= 4'h0;
            end else if (scl_q && !scl) begin
                if (bit_cnt < 4'h8) begin
                    sda_oe <= !tx_byte[3'h7 - bit_cnt[2:0]];
                    bit_cnt <= bit_cnt + 4'h1;
                end else begin
                    sda_oe <= 1'b0;
                end
            end
            if (burst) begin
                burst_cnt <= 3 * HALF;
            end else if (burst_cnt > 0) begin
                burst_cnt <= burst_cnt - 1;
            end
        end
    end
    // Low, high, low, then line released to idle high
    assign scl_oe = (burst_cnt > 2 * HALF) || (burst_cnt > 0 && burst_cnt <= HALF);
endmodule

// ===== tb_iackc_core.sv
// Self-checking testbench of the acknowledge control block
`timescale 1ns/1ps
module tb_iackc_core;
    import iackc_pkg::*;
    localparam int HALF = 4;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [ADDR_W-1:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic scl_oe;
    logic sda_oe;
    logic scl_out;
    logic sda_out;
    logic far_scl_oe;
    logic far_sda_oe;
    logic slot = 1'b0;
    logic arm = 1'b0;
    logic burst = 1'b0;
    logic [7:0] tx_byte = 8'h00;
    logic [31:0] rv;
    int n_fail = 0;
    int samples_checked = 0;
    // Open-drain lines with pull-ups
    wire logic scl = !(scl_oe || far_scl_oe);
    wire logic sda = !(sda_oe || far_sda_oe);

    iackc_core #(.HALF_CYC(HALF)) i_dut (
        .clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .serial_clock_pin_in(scl), .serial_clock_pin_out(scl_out),
        .serial_clock_pin_oe(scl_oe), .serial_data_pin_in(sda), .serial_data_pin_out(sda_out),
        .serial_data_pin_oe(sda_oe), .slave_ack_slot(slot));
    iackc_far_model #(.HALF(HALF)) i_far (
        .clk(clk), .sys_rst(sys_rst), .scl(scl), .tx_byte(tx_byte), .arm(arm),
        .burst(burst), .scl_oe(far_scl_oe), .sda_oe(far_sda_oe));

    initial begin
        forever #12.5 clk = ~clk;
    end
    // ************************************************************
    // Bus and checking tasks
    // ************************************************************
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic reg_rd(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        rv = rdata;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        reg_rd(a);
        check(rv, exp);
    endtask
    // Poll a control bit until hardware clears it
    task automatic wait_clear(input int bitn);
        int i;
        for (i = 0; i < 100; i++) begin
            reg_rd(OFS_CTRL);
            if (rv[bitn] === 1'b0) break;
        end
        if (i == 100) begin
            n_fail++;
            give_verdict();
        end
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_refuse();
        rd_chk(OFS_CTRL, 32'h0);
        rd_chk(OFS_STATUS, 32'h0);
        rd_chk(4'hC, 32'h0);
        reg_wr(OFS_CTRL, 32'h0000_0006);
        rd_chk(OFS_CTRL, 32'h0);
        reg_wr(OFS_CTRL, 32'h0000_0024);
        rd_chk(OFS_CTRL, 32'h20);
        reg_wr(OFS_CTRL, 32'h0000_0022);
        rd_chk(OFS_CTRL, 32'h20);
        reg_wr(4'hC, 32'hFFFF_FFFF);
        rd_chk(OFS_CTRL, 32'h20);
        check({30'h0, scl_oe, sda_oe}, 32'h0);
    endtask
    task automatic t_master_rx(input logic [7:0] b, input logic v);
        @(posedge clk);
        tx_byte <= b;
        arm <= 1'b1;
        @(posedge clk);
        arm <= 1'b0;
        reg_wr(OFS_CTRL, 32'h24);
        rd_chk(OFS_CTRL, 32'h24);
        wait_clear(CTRL_RX_TRIG);
        rd_chk(OFS_RXDATA, {24'h0, b});
        rd_chk(OFS_STATUS, 32'h2);
        check({31'h0, scl_oe}, 32'h1);
        reg_wr(OFS_CTRL, 32'h22 | {31'h0, v});
        check({30'h0, scl_oe, sda_oe}, {30'h0, 1'b1, !v});
        check({30'h0, scl_out, sda_out}, 32'h0);
        rd_chk(OFS_CTRL, 32'h22 | {31'h0, v});
        check({31'h0, sda_oe}, {31'h0, !v});
        wait_clear(CTRL_ACK_TRIG);
        check({30'h0, scl_oe, sda_oe}, 32'h0);
        rd_chk(OFS_STATUS, 32'h0);
    endtask
    // Config bits: data hold, address hold, value
    task automatic t_slave(input logic [2:0] cfg, input logic exp_oe);
        reg_wr(OFS_CTRL, {27'h0, cfg[2:1], 2'b00, cfg[0]});
        @(posedge clk);
        slot <= 1'b1;
        @(posedge clk);
        slot <= 1'b0;
        @(posedge clk);
        #1;
        check({31'h0, sda_oe}, {31'h0, exp_oe});
        rd_chk(OFS_STATUS, 32'h4);
        @(posedge clk);
        burst <= 1'b1;
        @(posedge clk);
        burst <= 1'b0;
        repeat (3 * HALF + 4) @(posedge clk);
        #1;
        check({31'h0, sda_oe}, 32'h0);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        t_refuse();
        t_master_rx(8'hA5, 1'b0);
        t_master_rx(8'h3C, 1'b1);
        t_slave(3'b001, 1'b1);
        t_slave(3'b011, 1'b0);
        t_slave(3'b100, 1'b1);
        t_slave(3'b111, 1'b0);
        give_verdict();
    end
endmodule
